// ===== logic/timer1_pkg.sv
// Notes on behaviour
// - Count register reads live counter low byte
// - Count write stores reload, loads counter
// - Counter runs only while enable set
// - Non-stop, no reload: underflow loads 0x3FF
// - Non-stop, reload: underflow loads reload value
// - One-shot counts down to zero, stops
// - Bypass bit selects high oscillator tick
// - Special clock bit overrides bypass bit
// - Polarity bit makes PWM active low
// - PWM enable drives PWM onto pad
// - Toggle enable drives underflow toggle onto pad
// - Toggle output wins over PWM on pad
// - Rate code selects divide 2 to 256
// - Prescaler disable bit bypasses prescaler
// - Edge select picks falling or rising edge
// - Source select picks pin or instruction clock
// - PWM period reload, duty ten bits
// - Prescaler view reads live prescaler count
// - Buzzer picks prescaler or counter bit
// - Buzzer enable gates buzzer output
package timer1_pkg;

  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_TIMER_COUNT = 3'h0;
  localparam logic [2:0] IDX_CTRL_ONE = 3'h1;
  localparam logic [2:0] IDX_CTRL_TWO = 3'h2;
  localparam logic [2:0] IDX_DUTY_LOW = 3'h3;
  localparam logic [2:0] IDX_PRESC_VIEW = 3'h4;
  localparam logic [2:0] IDX_BUZZER = 3'h5;
  localparam logic [2:0] IDX_HIGH_BITS = 3'h6;
  localparam logic [2:0] IDX_STATUS = 3'h7;

  // Control one fields
  localparam int C1_ENABLE = 0;
  localparam int C1_RELOAD_SEL = 1;
  localparam int C1_ONE_SHOT = 2;
  localparam int C1_HIGH_BYPASS = 3;
  localparam int C1_SPECIAL = 4;
  localparam int C1_TOGGLE_OE = 5;
  localparam int C1_PWM_POL = 6;
  localparam int C1_PWM_OE = 7;

  // Control two fields
  localparam int C2_RATE_LSB = 0;
  localparam int C2_PRESC_DIS_N = 3;
  localparam int C2_EDGE_SEL = 4;
  localparam int C2_SRC_SEL = 5;

  // High bits fields
  localparam int HB_DUTY_LSB = 0;
  localparam int HB_RELOAD_LSB = 4;

  // Buzzer fields
  localparam int BZ_FSEL_LSB = 0;
  localparam int BZ_ENABLE = 7;

  localparam int STAT_EVENT = 0;

  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [5:0] CTRL_TWO_RESET = 6'h3F;
  localparam logic [7:0] BUZZER_RESET = 8'h0F;
  localparam logic [7:0] PRESC_RESET = 8'hFF;
  localparam logic [9:0] COUNT_MAX = 10'h3FF;
  localparam logic [9:0] COUNT_ZERO = 10'h000;
  localparam logic [7:0] ADDR_HIGH_ZERO = 8'h00;

  typedef struct packed {
    logic [7:0] ctrl_one;
    logic [5:0] ctrl_two;
    logic [7:0] reload_low;
    logic [5:0] high_bits;
    logic [7:0] duty_low;
    logic [7:0] buzzer;
    logic [9:0] count;
    logic [7:0] presc;
    logic done;
    logic toggle;
    logic event_flag;
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic buzzer_out;
    logic [31:0] prdata;
    logic pslverr;
  } state_t;

endpackage

// ===== logic/timer1_prescaler_pwm1.sv
`timescale 1ns/100ps
module timer1_prescaler_pwm1 (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources, one-cycle enables on pclk
  input wire logic high_osc_tick,
  input wire logic special_osc_tick,
  // External clock pin, asynchronous
  input wire logic external_clock_pin,
  // Pad of the shared port pin
  input wire logic gpio_out,
  input wire logic gpio_oe_n,
  output logic pad_out,
  output logic pad_oe_n,
  // Buzzer and waveforms
  output logic buzzer_pin,
  output logic pwm_one_wave,
  output logic underflow_toggle_out,
  output logic timer_event
);

  timer1_pkg::state_t st_reg;
  timer1_pkg::state_t st_next;

  function automatic logic [7:0] rate_mask(input logic [2:0] rate);
    rate_mask = 8'hFF >> (3'h7 - rate);
  endfunction

  logic [2:0] idx;
  logic addr_ok;
  logic wr_en;
  logic setup;
  logic [9:0] reload_val;
  logic [9:0] duty_val;
  logic ext_edge;
  logic src_tick;
  logic presc_tick;
  logic timer_tick;
  logic [7:0] presc_dec;
  logic underflow;
  logic pwm_active;
  logic [3:0] fsel;
  logic [31:0] rd_val;

  assign idx = paddr[4:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && ({3'h0, paddr[7:5]} == 6'h00);
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && addr_ok && pstrb[0];
  assign pready = psel && penable;
  assign prdata = st_reg.prdata;
  assign pslverr = st_reg.pslverr;

  assign reload_val = {st_reg.high_bits[timer1_pkg::HB_RELOAD_LSB +: 2], st_reg.reload_low};
  assign duty_val = {st_reg.high_bits[timer1_pkg::HB_DUTY_LSB +: 2], st_reg.duty_low};
  assign fsel = st_reg.buzzer[timer1_pkg::BZ_FSEL_LSB +: 4];

  // Edge taken from the second and third stage only
  always_comb begin
    if (st_reg.ctrl_two[timer1_pkg::C2_EDGE_SEL]) begin
      ext_edge = st_reg.ext_prev && !st_reg.ext_sync;
    end else begin
      ext_edge = !st_reg.ext_prev && st_reg.ext_sync;
    end
  end

  always_comb begin
    if (st_reg.ctrl_one[timer1_pkg::C1_SPECIAL]) begin
      src_tick = special_osc_tick;
    end else if (st_reg.ctrl_one[timer1_pkg::C1_HIGH_BYPASS]) begin
      src_tick = high_osc_tick;
    end else if (st_reg.ctrl_two[timer1_pkg::C2_SRC_SEL]) begin
      src_tick = ext_edge;
    end else begin
      src_tick = 1'b1;
    end
  end

  // Prescaler ticks when the selected low bits all reach zero
  assign presc_dec = st_reg.presc - 8'h01;
  assign presc_tick = src_tick
    && ((presc_dec & rate_mask(st_reg.ctrl_two[timer1_pkg::C2_RATE_LSB +: 3])) == 8'h00);

  always_comb begin
    if (st_reg.ctrl_two[timer1_pkg::C2_PRESC_DIS_N]) begin
      timer_tick = src_tick;
    end else begin
      timer_tick = presc_tick;
    end
  end

  assign underflow = st_reg.ctrl_one[timer1_pkg::C1_ENABLE] && timer_tick && !st_reg.done
    && (st_reg.count == timer1_pkg::COUNT_ZERO);

  assign pwm_active = st_reg.count < duty_val;
  assign pwm_one_wave = pwm_active ^ st_reg.ctrl_one[timer1_pkg::C1_PWM_POL];
  assign underflow_toggle_out = st_reg.toggle;
  assign timer_event = st_reg.event_flag;
  assign buzzer_pin = st_reg.buzzer_out;

  // Pad mux, toggle output first
  always_comb begin
    if (st_reg.ctrl_one[timer1_pkg::C1_TOGGLE_OE]) begin
      pad_out = st_reg.toggle;
      pad_oe_n = 1'b0;
    end else if (st_reg.ctrl_one[timer1_pkg::C1_PWM_OE]) begin
      pad_out = pwm_one_wave;
      pad_oe_n = 1'b0;
    end else begin
      pad_out = gpio_out;
      pad_oe_n = gpio_oe_n;
    end
  end

  // Read data; write-only registers read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (idx)
      timer1_pkg::IDX_TIMER_COUNT: rd_val[7:0] = st_reg.count[7:0];
      timer1_pkg::IDX_CTRL_ONE: rd_val[7:0] = st_reg.ctrl_one;
      timer1_pkg::IDX_CTRL_TWO: rd_val[5:0] = st_reg.ctrl_two;
      timer1_pkg::IDX_DUTY_LOW: rd_val[7:0] = 8'h00;
      timer1_pkg::IDX_PRESC_VIEW: rd_val[7:0] = st_reg.presc;
      timer1_pkg::IDX_BUZZER: rd_val[7:0] = 8'h00;
      timer1_pkg::IDX_HIGH_BITS: rd_val[5:0] = st_reg.high_bits;
      timer1_pkg::IDX_STATUS: rd_val[timer1_pkg::STAT_EVENT] = st_reg.event_flag;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.ext_meta = external_clock_pin;
    st_next.ext_sync = st_reg.ext_meta;
    st_next.ext_prev = st_reg.ext_sync;

    if (setup) begin
      st_next.prdata = addr_ok ? rd_val : 32'h0000_0000;
      st_next.pslverr = !addr_ok;
    end

    // Prescaler runs only while inserted and the timer is enabled
    if (st_reg.ctrl_one[timer1_pkg::C1_ENABLE] && !st_reg.ctrl_two[timer1_pkg::C2_PRESC_DIS_N]
        && src_tick) begin
      st_next.presc = presc_dec;
    end

    if (st_reg.ctrl_one[timer1_pkg::C1_ENABLE] && timer_tick && !st_reg.done) begin
      if (st_reg.count != timer1_pkg::COUNT_ZERO) begin
        st_next.count = st_reg.count - 10'h001;
      end else if (st_reg.ctrl_one[timer1_pkg::C1_ONE_SHOT]) begin
        st_next.done = 1'b1;
      end else if (st_reg.ctrl_one[timer1_pkg::C1_RELOAD_SEL]) begin
        st_next.count = reload_val;
      end else begin
        st_next.count = timer1_pkg::COUNT_MAX;
      end
    end
    if (underflow) begin
      st_next.toggle = !st_reg.toggle;
    end

    if (wr_en) begin
      unique case (idx)
        timer1_pkg::IDX_TIMER_COUNT: begin
          st_next.reload_low = pwdata[7:0];
          st_next.count = {st_reg.high_bits[timer1_pkg::HB_RELOAD_LSB +: 2], pwdata[7:0]};
          st_next.done = 1'b0;
        end
        timer1_pkg::IDX_CTRL_ONE: begin
          st_next.ctrl_one = pwdata[7:0];
          if (!pwdata[timer1_pkg::C1_ONE_SHOT]) begin
            st_next.done = 1'b0;
          end
        end
        timer1_pkg::IDX_CTRL_TWO: st_next.ctrl_two = pwdata[5:0];
        timer1_pkg::IDX_DUTY_LOW: st_next.duty_low = pwdata[7:0];
        // Read-only view: leave the running prescaler untouched
        timer1_pkg::IDX_PRESC_VIEW: st_next.presc = st_next.presc;
        timer1_pkg::IDX_BUZZER: st_next.buzzer = pwdata[7:0];
        timer1_pkg::IDX_HIGH_BITS: st_next.high_bits = pwdata[5:0];
        timer1_pkg::IDX_STATUS: begin
          if (pwdata[timer1_pkg::STAT_EVENT]) begin
            st_next.event_flag = 1'b0;
          end
        end
      endcase
    end
    // Set after the clear so a same-cycle underflow is kept
    if (underflow) begin
      st_next.event_flag = 1'b1;
    end

    // Buzzer: low codes follow inverted prescaler bits, high codes counter bits
    if (!st_reg.buzzer[timer1_pkg::BZ_ENABLE]) begin
      st_next.buzzer_out = 1'b0;
    end else if (!fsel[3]) begin
      st_next.buzzer_out = !st_reg.presc[fsel[2:0]];
    end else begin
      st_next.buzzer_out = st_reg.count[fsel[2:0]];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.ctrl_one <= timer1_pkg::CTRL_ONE_RESET;
      st_reg.ctrl_two <= timer1_pkg::CTRL_TWO_RESET;
      st_reg.buzzer <= timer1_pkg::BUZZER_RESET;
      st_reg.presc <= timer1_pkg::PRESC_RESET;
      st_reg.count <= timer1_pkg::COUNT_MAX;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// ===== verification/timer1_sva.sv
`timescale 1ns/100ps
module timer1_sva (
  // Bus
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic [7:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // Pad and waves
  input logic gpio_out,
  input logic pad_out,
  input logic pad_oe_n,
  input logic pwm_one_wave,
  input logic underflow_toggle_out,
  input logic timer_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_access: assert property (pready == (psel && penable))
    else $error("ready mismatch");
  chk_misaligned_err: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("no error on misaligned access");
  chk_err_data_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("data on error");
  chk_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_toggle_event: assert property ($changed(underflow_toggle_out) |-> timer_event)
    else $error("toggle without event");
  chk_event_cause: assert property ($rose(timer_event) |-> $changed(underflow_toggle_out))
    else $error("event without toggle");
  chk_pad_source: assert property (!pad_oe_n && pad_out != gpio_out |->
    pad_out == underflow_toggle_out || pad_out == pwm_one_wave)
    else $error("pad from unknown source");
  chk_pad_gpio: assert property (pad_oe_n |-> pad_out == gpio_out)
    else $error("idle pad not gpio");
endmodule
bind timer1_prescaler_pwm1 timer1_sva timer1_sva_inst (.pclk, .presetn, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .gpio_out, .pad_out, .pad_oe_n, .pwm_one_wave,
  .underflow_toggle_out, .timer_event);

// ===== verification/ext_clock_model.sv
`timescale 1ns/100ps
module ext_clock_model (
  input logic pclk,
  input logic go,
  input logic [4:0] toggles,
  output logic external_clock_pin
);
  logic [7:0] left = 8'h00;
  logic go_q = 1'b0;
  initial external_clock_pin = 1'b0;
  // Pin stands still outside bursts
  always @(posedge pclk) begin
    go_q <= go;
    if (go && !go_q) left <= {1'b0, toggles, 2'h0};
    else if (left != 8'h00) left <= left - 8'h01;
    if (left[1:0] == 2'h1) external_clock_pin <= ~external_clock_pin;
  end
endmodule

// ===== verification/tb_timer1_prescaler_pwm1.sv
`timescale 1ns/100ps
module tb_timer1_prescaler_pwm1;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, er, external_clock_pin, pad_out, pad_oe_n, buzzer_pin;
  logic high_osc_tick = 1'b0, special_osc_tick = 1'b0, gpio_out = 1'b0, gpio_oe_n = 1'b1;
  logic pwm_one_wave, underflow_toggle_out, timer_event;
  logic [4:0] toggles = 5'h00;
  logic [1:0] cyc = 2'h0;
  logic [9:0] v;
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  logic [7:0] rv [6] = '{8'hFF, 8'h00, 8'h3F, 8'h00, 8'hFF, 8'h00};
  logic [7:0] md [3] = '{8'h01, 8'h03, 8'h05};
  logic [7:0] ex [3] = '{8'hFF, 8'h00, 8'h00};
  int bad_count = 0, num_checks = 0;
  timer1_prescaler_pwm1 timer1_prescaler_pwm1_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .high_osc_tick,
    .special_osc_tick, .external_clock_pin, .gpio_out, .gpio_oe_n, .pad_out, .pad_oe_n,
    .buzzer_pin, .pwm_one_wave, .underflow_toggle_out, .timer_event);
  ext_clock_model ext_clock_model_inst (.pclk, .go, .toggles, .external_clock_pin);
  always #10 pclk = ~pclk;
  // Oscillator enables: high every second edge, special every fourth
  always @(posedge pclk) begin
    cyc <= cyc + 2'h1;
    high_osc_tick <= cyc[0];
    special_osc_tick <= (cyc == 2'h0);
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Count runs k+3 edges between the enable and disable writes
  task automatic run(input logic [7:0] c2, input logic [7:0] c1, input logic [9:0] st,
                     input int k, input logic [7:0] e, input logic [4:0] tg);
    xf(1'b1, 8'h18, {2'h0, st[9:8], 4'h0});
    xf(1'b1, 8'h08, c2 | 8'h08);
    xf(1'b1, 8'h08, c2);
    xf(1'b1, 8'h00, st[7:0]);
    xf(1'b1, 8'h04, c1);
    toggles <= tg;
    go <= 1'b1;
    repeat (k) @(posedge pclk);
    go <= 1'b0;
    xf(1'b1, 8'h04, 8'h00);
    xf(1'b0, 8'h00, 8'h00);
    chk("count", {24'h0, e}, rd);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    wrap_up;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    xf(1'b1, 8'h10, 8'h00);
    for (int i = 0; i < 6; i++) begin
      xf(1'b0, ra[i], 8'h00);
      chk("reset value", {24'h0, rv[i]}, rd);
    end
    xf(1'b0, 8'h20, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, er});
    for (int i = 0; i < 3; i++) begin
      xf(1'b1, 8'h1C, 8'h01);
      run(8'h08, md[i], 10'h002, i * 5, ex[i], 5'h00);
      if (i < 2) chk("event", 32'h1, {31'h0, timer_event});
      if (i < 2) chk("toggle", 32'h1, {31'h0, underflow_toggle_out});
    end
    for (int r = 0; r < 8; r++) begin
      v = 10'h3FF - (10'h200 >> (r + 1));
      run(r[7:0], 8'h01, 10'h3FF, 509, v[7:0], 5'h00);
    end
    run(8'h28, 8'h01, 10'h3FF, 50, 8'hFA, 5'h09);
    run(8'h38, 8'h01, 10'h3FF, 50, 8'hFA, 5'h09);
    run(8'h28, 8'h09, 10'h3FF, 13, 8'hF7, 5'h00);
    run(8'h28, 8'h19, 10'h3FF, 13, 8'hFB, 5'h00);
    gpio_out <= 1'b1;
    @(negedge pclk);
    chk("pad gpio", 32'h3, {30'h0, pad_out, pad_oe_n});
    gpio_out <= 1'b0;
    xf(1'b1, 8'h18, 8'h00);
    xf(1'b1, 8'h00, 8'h10);
    xf(1'b1, 8'h0C, 8'h20);
    xf(1'b1, 8'h04, 8'h80);
    @(negedge pclk);
    chk("pwm pad", 32'h6, {29'h0, pwm_one_wave, pad_out, pad_oe_n});
    xf(1'b1, 8'h04, 8'hA0);
    @(negedge pclk);
    chk("toggle wins", 32'h4, {29'h0, pwm_one_wave, pad_out, pad_oe_n});
    xf(1'b1, 8'h14, 8'h8C);
    repeat (2) @(negedge pclk);
    chk("buzzer on", 32'h1, {31'h0, buzzer_pin});
    xf(1'b1, 8'h14, 8'h0C);
    repeat (2) @(negedge pclk);
    chk("buzzer off", 32'h0, {31'h0, buzzer_pin});
    xf(1'b1, 8'h04, 8'hC0);
    @(negedge pclk);
    chk("pwm inverted", 32'h0, {31'h0, pwm_one_wave});
    wrap_up;
  end
endmodule
